// ### design/skspc_ctrl.sv
// Secure key store program and read control with its register port.
//
// Behaviour
// - Target bit picks key RAM or OTP.
// - Mirror bit shows configuration programmed flag.
// - Interrupt pulse on completion when enabled.
// - Read trigger starts read, clears on completion.
// - Page 0 config, 1-8 keys, rest reserved.
// - Program trigger writes buffer, clears on completion.
// - Disable clears control fields; reset clears all but read trigger.
// - Program trigger cleared by disable or stop.
// - Config bits program once, bit 31 kept.
// - Config bit 30 shows page programmed.
// - Bits 29-28 give key RAM key type.
// - Pair type fields at bits 27-20.
// - Pair fields share one key type encoding.
// - Bits 21-20 give pages 1-2 type.
// - Write lock bit forbids OTP page programming.
// - Reserved or locked page sets fail, refuses.
// - Source lock selects locked key source.
`timescale 1ns/100ps
module skspc_ctrl
    import skspc_pkg::*;
#(
    parameter int PAGES = 8,
    parameter int PROG_CYC = PROG_CYCLES,
    parameter int READ_CYC = READ_CYCLES
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register port.
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Software key source from the cipher control.
    input wire logic [3:0] i_sw_key_source,
    // Status and key policy.
    output logic o_store_irq,
    output logic o_engine_busy,
    output skspc_policy_t o_key_policy
);

    logic target_reg, irq_en_reg, mirror_reg;
    logic read_trig_reg, prog_trig_reg;
    logic [3:0] page_reg;
    logic on_reg, go_reg, disable_reg;
    logic fail_reg, init_reg, op_prog_reg;
    logic [63:0] data_reg, rbuf_reg;
    logic [63:0] otp_reg [0:PAGES];
    logic [63:0] ram_reg [1:PAGES];
    logic [63:0] prog_word;
    logic [31:0] cfg;
    logic [CNT_W-1:0] cnt_reg;
    skspc_state_t state_reg;
    logic wr_ctl, wr_eng, idle, abort, done_rd, start;
    logic [15:0] ctl_view;

    // A page is refused when reserved, or locked in the array.
    function automatic logic page_refused(input logic [3:0] page,
                                          input logic ram,
                                          input logic [31:0] cw);
        logic [8:0] lock;
        lock = cw[CFG_PAGE_WRITE_LOCK_LO +: 9];
        if (page > PAGE_LAST) begin
            page_refused = 1'b1;
        end else if (ram) begin
            page_refused = (page == PAGE_CFG);
        end else begin
            page_refused = lock[page];
        end
    endfunction

    // Priority decode of the locked key source field.
    function automatic logic [3:0] locked_source(input logic [7:0] f);
        casez (f)
            8'b1???????: locked_source = 4'hf;
            8'b01??????: locked_source = 4'h7;
            8'b001?????: locked_source = 4'h6;
            8'b0001????: locked_source = 4'h5;
            8'b00001???: locked_source = 4'h5;
            8'b000001??: locked_source = 4'h3;
            8'b0000001?: locked_source = 4'h2;
            8'b00000001: locked_source = 4'h1;
            default: locked_source = 4'h0;
        endcase
    endfunction

    // Access decode and sequencer conditions.
    assign cfg = otp_reg[0][31:0];
    assign wr_ctl = i_wr && (i_addr == OFS_CTL);
    assign wr_eng = i_wr && (i_addr == OFS_ENG);
    assign idle = (state_reg == ST_IDLE);
    assign abort = disable_reg || (!go_reg && !init_reg);
    assign done_rd = (state_reg == ST_DONE) && !op_prog_reg;
    assign start = idle && (init_reg || (on_reg && go_reg
                   && (read_trig_reg || prog_trig_reg)));
    assign ctl_view = {7'h00, target_reg, mirror_reg, irq_en_reg,
                       read_trig_reg, page_reg, prog_trig_reg};
    // Busy is the low state bit, so the output needs no extra flop.
    assign o_engine_busy = state_reg[0];

    // The configuration page keeps bit 31 and always marks itself done.
    always_comb begin
        prog_word = data_reg;
        if (page_reg == PAGE_CFG) begin
            prog_word[63:32] = 32'h0;
            prog_word[CFG_RSVD] = 1'b0;
            prog_word[CFG_PROGRAMMED] = 1'b1;
        end
    end

    // Control fields; frozen during an operation so the page cannot move.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            target_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            page_reg <= PAGE_CFG;
        end else if (disable_reg) begin
            target_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            page_reg <= PAGE_CFG;
        end else if (wr_ctl && idle && !read_trig_reg && !prog_trig_reg) begin
            target_reg <= i_wdata[CTL_TARGET];
            irq_en_reg <= i_wdata[CTL_IRQ_EN];
            page_reg <= i_wdata[CTL_PAGE_LO +: 4];
        end
    end

    // Read trigger; set at reset so the configuration is loaded first.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_trig_reg <= CTL_READ_RESET;
        end else if (disable_reg || done_rd
                     || (state_reg == ST_RUN && abort)) begin
            read_trig_reg <= 1'b0;
        end else if (wr_ctl && idle && i_wdata[CTL_READ]
                     && !i_wdata[CTL_PROG] && !prog_trig_reg) begin
            read_trig_reg <= 1'b1;
        end
    end

    // Program trigger; a refused page never lets it set.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog_trig_reg <= 1'b0;
        end else if (disable_reg || (state_reg == ST_DONE && op_prog_reg)
                     || (state_reg == ST_RUN && abort)) begin
            prog_trig_reg <= 1'b0;
        end else if (wr_ctl && idle && i_wdata[CTL_PROG]
                     && !i_wdata[CTL_READ] && !read_trig_reg
                     && on_reg && !go_reg
                     && !page_refused(i_wdata[CTL_PAGE_LO +: 4],
                                      i_wdata[CTL_TARGET], cfg)) begin
            prog_trig_reg <= 1'b1;
        end
    end

    // Program fail flag follows the selected page and target.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fail_reg <= 1'b0;
        end else begin
            fail_reg <= page_refused(page_reg, target_reg, cfg);
        end
    end

    // Engine control; hardware drops the start bit when an operation ends.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            on_reg <= 1'b0;
            go_reg <= 1'b0;
            disable_reg <= 1'b0;
        end else if (wr_eng) begin
            on_reg <= i_wdata[ENG_ON];
            go_reg <= i_wdata[ENG_GO] && !i_wdata[ENG_DISABLE];
            disable_reg <= i_wdata[ENG_DISABLE];
        end else if (state_reg == ST_DONE || disable_reg) begin
            go_reg <= 1'b0;
        end
    end

    // Program data buffer, written a word at a time.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_reg <= 64'h0;
        end else if (i_wr && i_addr == OFS_DATA_LO) begin
            data_reg[31:0] <= i_wdata;
        end else if (i_wr && i_addr == OFS_DATA_HI) begin
            data_reg[63:32] <= i_wdata;
        end
    end

    // Operation sequencer: a fixed time per operation, then one done cycle.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            op_prog_reg <= 1'b0;
            init_reg <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_RUN;
                        op_prog_reg <= prog_trig_reg && !init_reg;
                        cnt_reg <= (prog_trig_reg && !init_reg)
                                   ? CNT_W'(PROG_CYC - 1)
                                   : CNT_W'(READ_CYC - 1);
                    end
                end
                ST_RUN: begin
                    if (abort) begin
                        state_reg <= ST_IDLE;
                        init_reg <= 1'b0;
                    end else if (cnt_reg == '0) begin
                        state_reg <= ST_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                    init_reg <= 1'b0;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Secure array: bits only ever go from zero to one.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int p = 0; p <= PAGES; p++) begin
                otp_reg[p] <= OTP_RESET;
            end
        end else if (state_reg == ST_DONE && op_prog_reg && !target_reg) begin
            otp_reg[page_reg] <= otp_reg[page_reg] | prog_word;
        end
    end

    // Key RAM is rewritable; page zero never reaches it.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int p = 1; p <= PAGES; p++) begin
                ram_reg[p] <= 64'h0;
            end
        end else if (state_reg == ST_DONE && op_prog_reg && target_reg) begin
            ram_reg[page_reg] <= data_reg;
        end
    end

    // Read buffer is loaded when a read completes; the mirror only when a configuration page read completes.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rbuf_reg <= 64'h0;
            mirror_reg <= 1'b0;
        end else if (disable_reg) begin
            mirror_reg <= 1'b0;
        end else if (done_rd) begin
            if (page_reg > PAGE_LAST) begin
                rbuf_reg <= 64'h0;
            end else if (target_reg && page_reg != PAGE_CFG) begin
                rbuf_reg <= ram_reg[page_reg];
            end else begin
                rbuf_reg <= otp_reg[page_reg];
            end
            if (page_reg == PAGE_CFG) begin
                mirror_reg <= cfg[CFG_PROGRAMMED];
            end
        end
    end

    // Completion pulse, one cycle after the done state.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_store_irq <= 1'b0;
        end else begin
            o_store_irq <= (state_reg == ST_DONE) && irq_en_reg;
        end
    end

    // Key policy, refreshed every cycle from the configuration page and, unless the source is locked, the software key source.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_key_policy <= '0;
        end else begin
            o_key_policy.ram_key_type <=
                skspc_key_type_t'(cfg[CFG_RAM_TYPE_LO +: 2]);
            for (int g = 0; g < 4; g++) begin
                o_key_policy.pair_key_type[g] <= skspc_key_type_t'(
                    cfg[CFG_PAIR_TYPE_LO + 2 * g +: 2]);
            end
            o_key_policy.session_key_only <= cfg[CFG_SESSION];
            o_key_policy.key_source_lock <= cfg[CFG_SRC_LOCK];
            o_key_policy.key_source <= cfg[CFG_SRC_LOCK]
                ? locked_source(cfg[CFG_LKSRC_LO +: 8])
                : i_sw_key_source;
            o_key_policy.soft_key_disable <= cfg[CFG_SWKEY_DIS];
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            case (i_addr)
                OFS_CTL: o_rdata <= {16'h0, ctl_view};
                OFS_CFG: o_rdata <= cfg;
                OFS_DATA_LO: o_rdata <= data_reg[31:0];
                OFS_DATA_HI: o_rdata <= data_reg[63:32];
                OFS_RBUF_LO: o_rdata <= rbuf_reg[31:0];
                OFS_RBUF_HI: o_rdata <= rbuf_reg[63:32];
                OFS_ENG: o_rdata <= {29'h0, disable_reg, go_reg, on_reg};
                OFS_STAT: o_rdata <= {24'h0, o_engine_busy, 6'h0, fail_reg};
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // Checks on the sequencer and registers.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    property p_ram_target;
        state_reg == ST_DONE && op_prog_reg && target_reg && page_reg == 4'h1
        |=> ram_reg[1] == $past(data_reg);
    endproperty
    a_ram_target: assert property (p_ram_target) else $error("ram miss");

    property p_mirror_view;
        i_rd && i_addr == OFS_CTL |=> o_rdata[CTL_MIRROR] == $past(mirror_reg);
    endproperty
    a_mirror_view: assert property (p_mirror_view) else $error("mirror");

    property p_irq;
        state_reg == ST_DONE
        |=> o_store_irq == $past(irq_en_reg) ##1 !o_store_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq pulse wrong");

    property p_read_done;
        done_rd |=> !read_trig_reg && state_reg == ST_IDLE;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read stuck");

    property p_reserved_fail;
        page_reg > PAGE_LAST ##1 page_reg > PAGE_LAST |-> fail_reg;
    endproperty
    a_reserved_fail: assert property (p_reserved_fail) else $error("fail");

    property p_prog_end;
        state_reg == ST_RUN && op_prog_reg && cnt_reg == '0 && !abort
        |=> state_reg == ST_DONE ##1 !prog_trig_reg && !go_reg;
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("prog end");

    property p_disable_clear;
        disable_reg |=> !target_reg && !irq_en_reg && page_reg == PAGE_CFG
                        && !mirror_reg && !prog_trig_reg;
    endproperty
    a_disable_clear: assert property (p_disable_clear) else $error("dis");

    property p_stop_clear;
        state_reg == ST_RUN && !go_reg && !init_reg |=> !prog_trig_reg;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop");

    property p_once;
        ((($past(cfg) & ~cfg) == 32'h0) && $stable(cfg[CFG_RSVD]));
    endproperty
    a_once: assert property (p_once) else $error("cfg bit fell");

    property p_refuse;
        wr_ctl && i_wdata[CTL_PROG] && !prog_trig_reg
        && page_refused(i_wdata[CTL_PAGE_LO +: 4], i_wdata[CTL_TARGET], cfg)
        |=> !prog_trig_reg;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused set");

    property p_src_lock;
        cfg[CFG_SRC_LOCK] |=> o_key_policy.key_source
                              == locked_source($past(cfg[CFG_LKSRC_LO +: 8]));
    endproperty
    a_src_lock: assert property (p_src_lock) else $error("src lock");

    c_prog: cover property (state_reg == ST_DONE && op_prog_reg);
    c_read: cover property (done_rd && !init_reg);
    c_fail: cover property (fail_reg ##1 wr_ctl && i_wdata[CTL_PROG]);
    c_abort: cover property (state_reg == ST_RUN && abort && !disable_reg);
endmodule

// ### design/skspc_pkg.sv
// Constants and types shared by the secure key store program control.
package skspc_pkg;
    // Register port geometry and word offsets.
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_DATA_LO = 8'h08;
    localparam logic [7:0] OFS_DATA_HI = 8'h0c;
    localparam logic [7:0] OFS_RBUF_LO = 8'h10;
    localparam logic [7:0] OFS_RBUF_HI = 8'h14;
    localparam logic [7:0] OFS_ENG = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    // Program control register fields.
    localparam int CTL_PROG = 0;
    localparam int CTL_PAGE_LO = 1;
    localparam int CTL_READ = 5;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_MIRROR = 7;
    localparam int CTL_TARGET = 8;
    localparam logic CTL_READ_RESET = 1'b1;
    // Engine control and status fields.
    localparam int ENG_ON = 0;
    localparam int ENG_GO = 1;
    localparam int ENG_DISABLE = 2;
    localparam int STAT_FAIL = 0;
    localparam int STAT_BUSY = 7;
    // Page numbers.
    localparam logic [3:0] PAGE_CFG = 4'h0;
    localparam logic [3:0] PAGE_LAST = 4'h8;
    // Configuration page fields.
    localparam int CFG_RSVD = 31;
    localparam int CFG_PROGRAMMED = 30;
    localparam int CFG_RAM_TYPE_LO = 28;
    localparam int CFG_PAIR_TYPE_LO = 20;
    localparam int CFG_SESSION = 19;
    localparam int CFG_LKSRC_LO = 11;
    localparam int CFG_SRC_LOCK = 10;
    localparam int CFG_PAGE_WRITE_LOCK_LO = 1;
    localparam int CFG_SWKEY_DIS = 0;
    localparam logic [63:0] OTP_RESET = 64'h0;
    // Operation timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 1000;
    localparam int READ_TIME_NS = 100;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_CYCLES = READ_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Key types allowed in a group of pages.
    typedef enum logic [1:0] {
        KT_DES = 2'b00,
        KT_TDES = 2'b01,
        KT_AES128 = 2'b10,
        KT_AES_LONG = 2'b11
    } skspc_key_type_t;
    // Key policy taken from the configuration page.
    typedef struct packed {
        skspc_key_type_t ram_key_type;
        skspc_key_type_t [3:0] pair_key_type;
        logic session_key_only;
        logic key_source_lock;
        logic [3:0] key_source;
        logic soft_key_disable;
    } skspc_policy_t;
    // Operation sequencer states, Gray coded from idle through run to done; done back to idle flips both bits.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } skspc_state_t;
endpackage

// ### tb/skspc_ctrl_tb.sv
// Self-checking bench for the secure key store program control.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module skspc_ctrl_tb;
    import skspc_pkg::*;
    // Short operation times keep the run brief.
    localparam int PC = 4;
    localparam int RC = 2;
    localparam logic [31:0] SRC_MAP = 32'hf7655321;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_sw_key_source = 4'h0;
    logic [31:0] o_rdata;
    logic o_store_irq;
    logic o_engine_busy;
    skspc_policy_t o_key_policy;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h14d0;
    logic [63:0] otp_exp [0:8];
    logic [63:0] ram_exp [0:8];
    int pgs [6] = '{1, 8, 3, 3, 3, 3};
    logic [63:0] d;
    logic [31:0] v;
    logic [31:0] cfgw;
    logic [31:0] cfg_exp;

    skspc_ctrl #(.PROG_CYC(PC), .READ_CYC(RC)) i_skspc_ctrl (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sw_key_source(i_sw_key_source), .o_store_irq(o_store_irq),
        .o_engine_busy(o_engine_busy), .o_key_policy(o_key_policy));

    // Free-running core clock.
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    // Cycle ceiling cuts a hang short well above the expected run length.
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // Repeatable pseudo-random words from a shift register.
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed;
    endfunction

    // Program control word from its fields.
    function automatic logic [31:0] ctlw(input logic pr, rb, ie, tg,
                                         input logic [3:0] pg);
        return {23'h0, tg, 1'b0, ie, rb, pg, pr};
    endfunction

    // Key policy expected from a configuration word.
    function automatic skspc_policy_t pol(input logic [31:0] c,
                                          input logic [3:0] sw);
        skspc_policy_t p;
        p.ram_key_type = skspc_key_type_t'(c[29:28]);
        for (int g = 0; g < 4; g++) begin
            p.pair_key_type[g] = skspc_key_type_t'(c[20+2*g +: 2]);
        end
        p.session_key_only = c[19];
        p.key_source_lock = c[10];
        p.key_source = c[10] ? 4'h0 : sw;
        for (int i = 0; i < 8; i++) begin
            if (c[10] && c[11+i]) begin
                p.key_source = SRC_MAP[4*i +: 4];
            end
        end
        p.soft_key_disable = c[0];
        return p;
    endfunction

    // One-cycle register write; the strobe drops on the next edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= dt;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // One-cycle read; data is taken in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [31:0] dt);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 dt = o_rdata;
    endtask

    // Launch one operation, count completion pulses over 30 cycles, then check once for idle.
    task automatic op(input logic [31:0] ctl, input int n_irq,
                      input logic abort);
        int irqs;
        logic seen;
        logic [31:0] r;
        irqs = 0;
        seen = abort;
        wr(OFS_ENG, 32'h1);
        wr(OFS_CTL, ctl);
        wr(OFS_ENG, 32'h3);
        if (abort) begin
            wr(OFS_ENG, 32'h1);
        end
        repeat (30) begin
            @(posedge i_core_clk);
            #1;
            irqs += (o_store_irq === 1'b1);
            seen |= (o_engine_busy === 1'b1);
        end
        `CHK("irq_count", n_irq, irqs)
        `CHK("busy_seen", 1'b1, seen)
        `CHK("busy_idle", 1'b0, o_engine_busy)
        rd(OFS_CTL, r);
        `CHK("triggers_idle", 32'h0, r & 32'h21)
    endtask

    // Read a page back through the read buffer.
    task automatic rd_page(input logic [3:0] pg, input logic tg);
        logic [63:0] e;
        logic [31:0] r;
        e = tg ? ram_exp[pg] : otp_exp[pg];
        op(ctlw(1'b0, 1'b1, 1'b1, tg, pg), 1, 1'b0);
        rd(OFS_RBUF_LO, r);
        `CHK("rbuf_lo", e[31:0], r)
        rd(OFS_RBUF_HI, r);
        `CHK("rbuf_hi", e[63:32], r)
    endtask

    // A refused program request leaves the trigger clear and flags failure.
    task automatic refuse(input logic [3:0] pg);
        logic [31:0] r;
        wr(OFS_ENG, 32'h1);
        wr(OFS_CTL, ctlw(1'b1, 1'b0, 1'b0, 1'b0, pg));
        rd(OFS_CTL, r);
        `CHK("prog_refused", 1'b0, r[CTL_PROG])
        rd(OFS_STAT, r);
        `CHK("prog_fail", 1'b1, r[STAT_FAIL])
    endtask

    // Verdict and end of run.
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        for (int i = 0; i < 9; i++) begin
            otp_exp[i] = 64'h0;
            ram_exp[i] = 64'h0;
        end
        i_sw_key_source <= 4'(rnd());
        repeat (12) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        // The power-up configuration read holds the read trigger set.
        rd(OFS_CTL, v);
        `CHK("ctl_init_read", 32'h20, v)
        repeat (20) @(posedge i_core_clk);
        rd(OFS_CTL, v);
        `CHK("ctl_idle", 32'h0, v)
        `CHK("pol_idle", pol('0, i_sw_key_source), o_key_policy)
        rd(8'h20, v);
        `CHK("unmapped", 32'h0, v)
        wr(OFS_CFG, 32'hffffffff);
        rd(OFS_CFG, v);
        `CHK("cfg_ro", 32'h0, v)
        // Both targets: the array ORs new data in, the key RAM overwrites.
        for (int k = 0; k < 6; k++) begin
            d = {rnd(), rnd()};
            wr(OFS_DATA_LO, d[31:0]);
            wr(OFS_DATA_HI, d[63:32]);
            op(ctlw(1'b1, 1'b0, k[0], k > 3, 4'(pgs[k])), k % 2, 1'b0);
            if (k > 3) begin
                ram_exp[pgs[k]] = d;
            end else begin
                otp_exp[pgs[k]] = otp_exp[pgs[k]] | d;
            end
            rd_page(4'(pgs[k]), k > 3);
        end
        refuse(4'h9);
        refuse(4'hf);
        // Configuration: every key type code, page 2 locked, source locked.
        cfgw = 32'hb9300408 | (32'h40 << 11) | (rnd() & 32'h00080001);
        cfg_exp = (cfgw | 32'h40000000) & 32'h7fffffff;
        wr(OFS_DATA_LO, cfgw);
        wr(OFS_DATA_HI, rnd());
        op(ctlw(1'b1, 1'b0, 1'b1, 1'b0, PAGE_CFG), 1, 1'b0);
        op(ctlw(1'b0, 1'b1, 1'b0, 1'b0, PAGE_CFG), 0, 1'b0);
        rd(OFS_CTL, v);
        `CHK("mirror", 1'b1, v[CTL_MIRROR])
        rd(OFS_CFG, v);
        `CHK("cfg_page", cfg_exp, v)
        `CHK("policy", pol(cfg_exp, i_sw_key_source), o_key_policy)
        `CHK("locked_src", 4'h7, o_key_policy.key_source)
        `CHK("pair_types", 8'h93, o_key_policy.pair_key_type)
        refuse(4'h2);
        // Clearing the start bit mid-run abandons a key RAM program.
        d = {rnd(), rnd()};
        wr(OFS_DATA_LO, d[31:0]);
        wr(OFS_DATA_HI, d[63:32]);
        op(ctlw(1'b1, 1'b0, 1'b1, 1'b1, 4'h5), 0, 1'b1);
        rd_page(4'h5, 1'b1);
        // Module disable clears the control fields, mirror included.
        wr(OFS_ENG, 32'h1);
        wr(OFS_CTL, ctlw(1'b0, 1'b0, 1'b1, 1'b1, 4'h4));
        rd(OFS_CTL, v);
        `CHK("ctl_fields", 32'h1c8, v)
        wr(OFS_ENG, 32'h4);
        rd(OFS_CTL, v);
        `CHK("ctl_disabled", 32'h0, v)
        wr(OFS_ENG, 32'h0);
        final_report();
    end
endmodule
